// File: logic/mta_pkg.sv
// Purpose: shared constants for the move-to-accumulator datapath
// Assumes: 12-bit instruction words, 8-bit data
// Notes: opcode patterns match under the masks below; OP_SEL is matched on the whole word
package mta_pkg;
   localparam int DATA_W = 8;
   localparam int INSN_W = 12;
   localparam int SEL_W = 5;
   // opcode match masks and values
   localparam logic [11:0] FR_MASK = 12'h0fe0;
   localparam logic [11:0] LIT_MASK = 12'h0f00;
   localparam logic [11:0] OP_DEC = 12'h00c0;
   localparam logic [11:0] OP_INC = 12'h0280;
   localparam logic [11:0] OP_RL = 12'h0340;
   localparam logic [11:0] OP_RR = 12'h0300;
   localparam logic [11:0] OP_SWAP = 12'h0380;
   localparam logic [11:0] OP_LIT = 12'h0c00;
   localparam logic [11:0] OP_SEL = 12'h0042;
   // reset values and datapath constants
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [7:0] SEL_RST = 8'h00;
   localparam logic [7:0] ZERO_8 = 8'h00;
   localparam logic [7:0] ONE_8 = 8'h01;
   localparam logic [7:0] FF_8 = 8'hff;
   localparam int LAT_CYC = 1;
endpackage : mta_pkg

// File: logic/mta_decode.sv
// Purpose: opcode match for one instruction pattern
// Assumes: pattern bits outside the mask are don't care
// Notes: instantiated once per operation
`timescale 1ns/1ps
`default_nettype none
module mta_decode #(
   parameter logic [11:0] MASK = 12'h0fff,
   parameter logic [11:0] VALUE = 12'h0000
) (
   // instruction
   input wire logic [11:0] insn_in,
   // match
   output logic hit_out
);
   // compare only the fixed opcode bits
   assign hit_out = ((insn_in & MASK) == VALUE);
endmodule : mta_decode
`default_nettype wire

// File: logic/mta_core.sv
// Purpose: datapath for single-operand ops that write the accumulator
// Assumes: file register read is combinational from operand_sel_out
// Notes: one result per issued instruction that matches a pattern, registered next edge
//
// Contract
// - decrement op writes operand minus one
// - decrement sets zero only for 01h source
// - increment op writes operand plus one
// - increment sets zero only for FFh source
// - rotate left through carry, carry only
// - rotate right through carry, carry only
// - nibble swap, no flags changed
// - literal load, no flags changed
// - selector steers later port-control writes
`timescale 1ns/1ps
`default_nettype none
module mta_core (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // instruction issue
   input wire logic issue_in,
   input wire logic [11:0] insn_in,
   // file register read port
   output logic [4:0] operand_sel_out,
   input wire logic [7:0] file_register_operand_in,
   // port-control selector load
   input wire logic sel_wr_in,
   input wire logic [7:0] sel_wdata_in,
   // results
   output logic [7:0] acc_out,
   output logic zero_out,
   output logic carry_out,
   output logic done_out,
   output logic [7:0] port_sel_out
);
   // ----------------------------------------------------------
   // decode
   // ----------------------------------------------------------
   logic hit_dec, hit_inc, hit_rl, hit_rr, hit_swap, hit_lit, hit_sel;
   mta_decode #(.MASK(mta_pkg::FR_MASK), .VALUE(mta_pkg::OP_DEC))
      u_dec (.insn_in(insn_in), .hit_out(hit_dec));
   mta_decode #(.MASK(mta_pkg::FR_MASK), .VALUE(mta_pkg::OP_INC))
      u_inc (.insn_in(insn_in), .hit_out(hit_inc));
   mta_decode #(.MASK(mta_pkg::FR_MASK), .VALUE(mta_pkg::OP_RL))
      u_rl (.insn_in(insn_in), .hit_out(hit_rl));
   mta_decode #(.MASK(mta_pkg::FR_MASK), .VALUE(mta_pkg::OP_RR))
      u_rr (.insn_in(insn_in), .hit_out(hit_rr));
   mta_decode #(.MASK(mta_pkg::FR_MASK), .VALUE(mta_pkg::OP_SWAP))
      u_swap (.insn_in(insn_in), .hit_out(hit_swap));
   mta_decode #(.MASK(mta_pkg::LIT_MASK), .VALUE(mta_pkg::OP_LIT))
      u_lit (.insn_in(insn_in), .hit_out(hit_lit));
   mta_decode #(.MASK(12'hfff), .VALUE(mta_pkg::OP_SEL))
      u_sel (.insn_in(insn_in), .hit_out(hit_sel));

   // f field picks the source register
   assign operand_sel_out = insn_in[4:0];

   // ----------------------------------------------------------
   // result selection
   // ----------------------------------------------------------
   logic [7:0] acc_reg, acc_next, sel_reg;
   logic zero_reg, zero_next, carry_reg, carry_next, done_reg;
   wire logic [7:0] opnd = file_register_operand_in;
   wire logic [7:0] dec_val = opnd - mta_pkg::ONE_8;
   wire logic [7:0] inc_val = opnd + mta_pkg::ONE_8;
   wire logic [7:0] rl_val = {opnd[6:0], carry_reg};
   wire logic [7:0] rr_val = {carry_reg, opnd[7:1]};
   wire logic [7:0] swap_val = {opnd[3:0], opnd[7:4]};
   wire logic any_hit = hit_dec | hit_inc | hit_rl | hit_rr | hit_swap
                        | hit_lit | hit_sel;
   wire logic take = issue_in & any_hit;

   // one mux; an unrecognised or idle word keeps state
   always_comb
   begin
      acc_next = acc_reg;
      zero_next = zero_reg;
      carry_next = carry_reg;
      if (issue_in)
      begin
         if (hit_dec)
         begin
            acc_next = dec_val;
            zero_next = (opnd == mta_pkg::ONE_8);
         end
         else if (hit_inc)
         begin
            acc_next = inc_val;
            zero_next = (opnd == mta_pkg::FF_8);
         end
         else if (hit_rl)
         begin
            acc_next = rl_val;
            carry_next = opnd[7];
         end
         else if (hit_rr)
         begin
            acc_next = rr_val;
            carry_next = opnd[0];
         end
         else if (hit_swap)
            acc_next = swap_val;
         else if (hit_lit)
            acc_next = insn_in[7:0];
         else if (hit_sel)
            acc_next = sel_reg;
      end
   end

   // ----------------------------------------------------------
   // state
   // ----------------------------------------------------------
   // result lands on the next edge: single-cycle ops
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         acc_reg <= mta_pkg::ACC_RST;
         zero_reg <= 1'b0;
         carry_reg <= 1'b0;
         done_reg <= 1'b0;
      end
      else
      begin
         acc_reg <= acc_next;
         zero_reg <= zero_next;
         carry_reg <= carry_next;
         done_reg <= take;
      end
   end

   // selector is loaded from outside; copy op never writes it
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         sel_reg <= mta_pkg::SEL_RST;
      else if (sel_wr_in)
         sel_reg <= sel_wdata_in;
   end

   assign acc_out = acc_reg;
   assign zero_out = zero_reg;
   assign carry_out = carry_reg;
   assign done_out = done_reg;
   assign port_sel_out = sel_reg;

   // ----------------------------------------------------------
   // checks
   // ----------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);

   a_dec_value: assert property (issue_in && hit_dec |=>
      acc_out == $past(opnd) - 8'h01) else $error("dec value wrong");
   a_dec_zero: assert property (issue_in && hit_dec |=>
      zero_out == ($past(opnd) == 8'h01)) else $error("dec zero wrong");
   a_inc_value: assert property (issue_in && hit_inc |=>
      acc_out == $past(opnd) + 8'h01) else $error("inc value wrong");
   a_inc_zero: assert property (issue_in && hit_inc |=>
      zero_out == ($past(opnd) == 8'hff)) else $error("inc zero wrong");
   a_rl_carry: assert property (issue_in && hit_rl |=>
      carry_out == $past(opnd[7]) && $stable(zero_out)
      && acc_out[0] == $past(carry_out)) else $error("rl wrong");
   a_rr_carry: assert property (issue_in && hit_rr |=>
      carry_out == $past(opnd[0]) && $stable(zero_out)
      && acc_out[7] == $past(carry_out)) else $error("rr wrong");
   a_swap_flags: assert property (issue_in && hit_swap |=>
      $stable(zero_out) && $stable(carry_out)
      && acc_out == {$past(opnd[3:0]), $past(opnd[7:4])})
      else $error("swap wrong");
   a_lit_load: assert property (issue_in && hit_lit |=>
      acc_out == $past(insn_in[7:0]) && $stable(carry_out))
      else $error("literal wrong");
   a_sel_copy: assert property (issue_in && hit_sel && !sel_wr_in |=>
      acc_out == port_sel_out && $stable(zero_out))
      else $error("selector copy wrong");
   a_done_one: assert property (take |=> done_out)
      else $error("op not done in one cycle");

   // ----------------------------------------------------------
   // hold and steering checks
   // ----------------------------------------------------------
   // both flags as they stood one edge earlier
   sequence s_flags_kept;
      $stable(zero_out) && $stable(carry_out);
   endsequence
   // acc and both flags as they stood one edge earlier
   sequence s_state_kept;
      $stable(acc_out) && $stable(zero_out) && $stable(carry_out);
   endsequence
   // done answers the taken op, then drops when nothing follows
   sequence s_one_pulse;
      done_out ##1 !done_out;
   endsequence

   // refused or idle words must not disturb acc, flags or done
   a_refuse_hold: assert property (!take |=> s_state_kept)
      else $error("refused word changed state");
   a_refuse_done: assert property (!take |=> !done_out)
      else $error("done raised without a taken op");
   a_done_pulse: assert property (take ##1 !take |-> s_one_pulse)
      else $error("done not a one cycle pulse");

   // full rotate result, not only the bit that enters
   a_rl_value: assert property (issue_in && hit_rl |=>
      acc_out == {$past(opnd[6:0]), $past(carry_out)})
      else $error("rl value wrong");
   a_rr_value: assert property (issue_in && hit_rr |=>
      acc_out == {$past(carry_out), $past(opnd[7:1])})
      else $error("rr value wrong");

   // flags that an op does not name stay where they were
   a_dec_carry: assert property (issue_in && hit_dec |=>
      $stable(carry_out)) else $error("dec touched carry");
   a_inc_carry: assert property (issue_in && hit_inc |=>
      $stable(carry_out)) else $error("inc touched carry");
   a_lit_flags: assert property (issue_in && hit_lit |=>
      s_flags_kept) else $error("literal touched flags");
   a_sel_flags: assert property (issue_in && hit_sel |=>
      s_flags_kept) else $error("selector copy touched flags");

   // selector moves only through its own load port
   a_sel_load: assert property (sel_wr_in |=>
      port_sel_out == $past(sel_wdata_in))
      else $error("selector load wrong");
   a_sel_hold: assert property (!sel_wr_in |=>
      $stable(port_sel_out)) else $error("selector moved without load");
endmodule : mta_core
`default_nettype wire

// File: tb/test_move_to_accumulator_ops.sv
// Purpose: self-checking bench for mta_core
// Assumes: results land one edge after the issuing edge
// Notes: the bench plays the file register read port itself
`timescale 1ns/1ps
`default_nettype none
module test_move_to_accumulator_ops;
   logic clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic issue_in = 1'b0;
   logic [11:0] insn_in = 12'h0000;
   logic [7:0] opnd = 8'h00;
   logic sel_wr_in = 1'b0;
   logic [7:0] sel_wdata_in = 8'h00;
   logic [4:0] operand_sel_out;
   logic [7:0] acc_out;
   logic [7:0] port_sel_out;
   logic zero_out;
   logic carry_out;
   logic done_out;
   int err_total = 0;
   int checks_done = 0;
   int cyc = 0;
   // ----------------------------------------
   // clock, device and hang guard
   // ----------------------------------------
   always #2 clk_in = ~clk_in;
   mta_core dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in),
      .issue_in(issue_in), .insn_in(insn_in),
      .operand_sel_out(operand_sel_out), .file_register_operand_in(opnd),
      .sel_wr_in(sel_wr_in), .sel_wdata_in(sel_wdata_in),
      .acc_out(acc_out), .zero_out(zero_out), .carry_out(carry_out),
      .done_out(done_out), .port_sel_out(port_sel_out));
   // the whole run needs well under 200 cycles
   always @(posedge clk_in)
   begin
      cyc <= cyc + 1;
      if (cyc == 2000)
      begin
         err_total++;
         results();
      end
   end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input string what, input logic [7:0] e,
                      input logic [7:0] g);
      checks_done++;
      if (g !== e)
      begin
         err_total++;
         $display("BAD %s exp %h got %h", what, e, g);
      end
   endtask : chk
   task automatic flg(input logic z, input logic c);
      chk("zero", {7'h00, z}, {7'h00, zero_out});
      chk("carry", {7'h00, c}, {7'h00, carry_out});
   endtask : flg
   // one idle edge, then one issued word; done must be high one edge after issue
   task automatic op(input logic [11:0] w, input logic [7:0] v);
      @(posedge clk_in);
      issue_in <= 1'b1;
      insn_in <= w;
      opnd <= v;
      #1;
      chk("opsel", {3'b000, w[4:0]}, {3'b000, operand_sel_out});
      @(posedge clk_in);
      issue_in <= 1'b0;
      #1;
      chk("done", 8'h01, {7'h00, done_out});
   endtask : op
   task automatic results();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : results
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_dec_inc();
      op(12'h0DF, 8'h01);
      chk("dec", 8'h00, acc_out);
      flg(1'b1, 1'b0);
      op(12'h0CA, 8'h00);
      chk("dec", 8'hff, acc_out);
      flg(1'b0, 1'b0);
      op(12'h293, 8'hff);
      chk("inc", 8'h00, acc_out);
      flg(1'b1, 1'b0);
      op(12'h280, 8'h75);
      chk("inc", 8'h76, acc_out);
      flg(1'b0, 1'b0);
   endtask : t_dec_inc
   // zero left set on purpose so a rotate that touches it is caught
   task automatic t_rot();
      op(12'h0C1, 8'h01);
      op(12'h345, 8'h80);
      chk("rl", 8'h00, acc_out);
      flg(1'b1, 1'b1);
      op(12'h358, 8'h14);
      chk("rl", 8'h29, acc_out);
      flg(1'b1, 1'b0);
      op(12'h340, 8'h80);
      op(12'h30F, 8'h12);
      chk("rr", 8'h89, acc_out);
      flg(1'b1, 1'b0);
   endtask : t_rot
   task automatic t_keep();
      op(12'h340, 8'h80);
      op(12'h38B, 8'ha5);
      chk("swap", 8'h5a, acc_out);
      flg(1'b1, 1'b1);
      op(12'hC75, 8'h00);
      chk("lit", 8'h75, acc_out);
      flg(1'b1, 1'b1);
      @(posedge clk_in);
      sel_wr_in <= 1'b1;
      sel_wdata_in <= 8'h1f;
      @(posedge clk_in);
      sel_wr_in <= 1'b0;
      #1;
      chk("psel", 8'h1f, port_sel_out);
      op(12'h042, 8'h00);
      chk("selcp", 8'h1f, acc_out);
      chk("psel", 8'h1f, port_sel_out);
      flg(1'b1, 1'b1);
   endtask : t_keep
   // idle and unknown words must leave everything alone
   task automatic t_refuse();
      // a literal word presented without issue
      @(posedge clk_in);
      insn_in <= 12'hC33;
      opnd <= 8'h00;
      // then an issued word that matches no pattern
      @(posedge clk_in);
      issue_in <= 1'b1;
      insn_in <= 12'h000;
      #1;
      chk("idle acc", 8'h1f, acc_out);
      chk("idle done", 8'h00, {7'h00, done_out});
      @(posedge clk_in);
      issue_in <= 1'b0;
      #1;
      chk("bad acc", 8'h1f, acc_out);
      chk("bad done", 8'h00, {7'h00, done_out});
      flg(1'b1, 1'b1);
   endtask : t_refuse
   initial
   begin
      repeat (10) @(posedge clk_in);
      chk("acc0", 8'h00, acc_out);
      chk("psel0", 8'h00, port_sel_out);
      flg(1'b0, 1'b0);
      rst_b_in <= 1'b1;
      t_dec_inc();
      t_rot();
      t_keep();
      t_refuse();
      results();
   end
endmodule : test_move_to_accumulator_ops
`default_nettype wire
